/* File: verilog/rsl_pkg.sv */
package rsl_pkg;
   // register offsets on the controller side
   localparam logic [7:0] RSL_ADDR_PIN_CTRL   = 8'h90;
   localparam logic [7:0] RSL_ADDR_SHIFT_DATA = 8'he5;
   localparam logic [7:0] RSL_ADDR_SPI_CTRL   = 8'he6;
   localparam logic [7:0] RSL_ADDR_STATUS     = 8'he7;
   // reset values
   localparam logic [7:0] RSL_RST_PIN_CTRL    = 8'h02;
   localparam logic [7:0] RSL_RST_SHIFT_DATA  = 8'h00;
   localparam logic [7:0] RSL_RST_SPI_CTRL    = 8'h00;
   // field positions
   localparam int RSL_BIT_LINK_EN  = 4;
   localparam int RSL_BIT_CLK_EN   = 2;
   localparam int RSL_BIT_CSN      = 1;
   localparam int RSL_BIT_RADIO_EN = 0;
   // command words
   localparam logic [7:0] RSL_CMD_RX_READ    = 8'h61;
   localparam logic [7:0] RSL_CMD_TX_WRITE   = 8'ha0;
   localparam logic [7:0] RSL_CMD_FLUSH_TX   = 8'he1;
   localparam logic [7:0] RSL_CMD_FLUSH_RX   = 8'he2;
   localparam logic [7:0] RSL_CMD_REUSE      = 8'he3;
   localparam logic [7:0] RSL_CMD_ACTIVATE   = 8'h50;
   localparam logic [7:0] RSL_ACTIVATE_KEY   = 8'h73;
   localparam logic [7:0] RSL_CMD_RX_WIDTH   = 8'h60;
   localparam logic [7:0] RSL_CMD_NOACK_WR   = 8'hb0;
   localparam logic [7:0] RSL_CMD_NOP        = 8'hff;
   localparam logic [4:0] RSL_ACK_WR_PREFIX  = 5'b10101;
   localparam logic [2:0] RSL_MAX_PIPE       = 3'b101;
   localparam int RSL_MAX_REG_BYTES = 5;
   localparam int RSL_MAX_PAYLOAD   = 32;
   localparam int RSL_NUM_REGS      = 32;
   localparam int RSL_ACK_DEPTH     = 3;
   // clocking: the radio core clock is the system clock gated
   localparam int RSL_CLK_HZ        = 25_000_000;
   localparam int RSL_REUSE_PULSE_NS = 10_000;
   localparam int RSL_REUSE_PULSE_CYC =
      (RSL_REUSE_PULSE_NS * (RSL_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [8:0] RSL_REUSE_CYC = 9'(RSL_REUSE_PULSE_CYC);
   localparam logic [5:0] RSL_DIV_MAX_HALF = 6'd31;
endpackage : rsl_pkg

/* File: verilog/rsl_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rsl_link_if;
   logic sck;      // serial clock, idle low
   logic mosi;     // controller to radio
   logic miso;     // radio to controller
   logic csn;      // chip select, active low
   logic ce;       // radio enable
   logic core_clk_en; // gate for the radio core clock
   modport ctrl  (output sck, output mosi, output csn, output ce, output core_clk_en,
                  input miso);
   modport radio (input sck, input mosi, input csn, input ce, input core_clk_en,
                  output miso);
endinterface : rsl_link_if
`default_nettype wire

/* File: verilog/rsl_clk_div.sv */
`timescale 1ns/1ps
`default_nettype none
// one-cycle enable pulse at each serial clock half period
module rsl_clk_div
   import rsl_pkg::*;
(
   input  wire logic       i_clock,
   input  wire logic       i_reset_n,
   input  wire logic       i_run,
   input  wire logic [3:0] i_div_code,
   output logic            o_half_tick
);
   logic [5:0] half_lim;
   logic [5:0] cnt_ff;

   // code to half-period length minus one
   always_comb begin
      case (i_div_code)
         4'h0, 4'h1: half_lim = 6'd0;
         4'h2:       half_lim = 6'd1;
         4'h3:       half_lim = 6'd3;
         4'h4:       half_lim = 6'd7;
         4'h5:       half_lim = 6'd15;
         default:    half_lim = RSL_DIV_MAX_HALF;
      endcase
   end

   // counter restarts each transfer so the first half period is full length
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_ff      <= 6'h00;
         o_half_tick <= 1'b0;
      end else if (!i_run) begin
         cnt_ff      <= 6'h00;
         o_half_tick <= 1'b0;
      end else if (cnt_ff >= half_lim) begin
         cnt_ff      <= 6'h00;
         o_half_tick <= 1'b1;
      end else begin
         cnt_ff      <= cnt_ff + 6'h01;
         o_half_tick <= 1'b0;
      end
   end
endmodule : rsl_clk_div
`default_nettype wire

/* File: verilog/rsl_ctrl.sv */
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - writing data register starts one byte transfer
// - link enable bit gates all transfers
// - divider code picks serial clock rate
// - clock enable bit gates radio core clock
// - chip select bit, resets deselected, 0x02
// - radio enable bit drives enable line
// - each command starts with select low
// - command byte then data, low byte first
// - register read returns one to five bytes
// - register write only in standby or down
// - payload read returns and removes bytes
// - payload write loads transmit buffer
// - flush commands empty transmit or receive
// - avoid receive flush during acknowledge
// - reuse command resends on enable pulses
// - activate with 0x73 toggles extra features
// - inactive extras ignore writes, read zero
// - width command returns head payload width
// - ack payload per pipe, three pending
// - no-ack payload write suppresses acknowledge
// - no operation command returns status
// - partial register write keeps upper bytes
// - status loaded into data on select; the code loads the byte kept from the previous command
module rsl_ctrl
   import rsl_pkg::*;
(
   input  wire logic       i_clock,
   input  wire logic       i_reset_n,
   // avalon-mm slave
   input  wire logic [7:0] i_avs_address,
   input  wire logic       i_avs_read,
   input  wire logic       i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic [31:0]     o_avs_readdata,
   output logic            o_avs_waitrequest,
   rsl_link_if.ctrl        link
);
   typedef enum logic [1:0] {
      RSL_IDLE  = 2'b00,
      RSL_SHIFT = 2'b01,
      RSL_DONE  = 2'b10
   } rsl_state_t;

   rsl_state_t state_ff;
   logic [7:0] pin_ctrl_ff;
   logic [7:0] spi_ctrl_ff;
   logic [7:0] shift_ff;
   logic [3:0] half_cnt_ff;
   logic       sck_ff;
   logic       mosi_ff;
   logic       csn_ff;
   logic       ce_ff;
   logic       clk_en_ff;
   logic       csn_prev_ff;
   logic       load_status_ff;
   logic       half_tick;
   logic       acc_ff;
   logic       wr_pin;
   logic       wr_data;
   logic       wr_ctl;
   logic       link_on;
   logic       first_ff;
   logic [7:0] status_byte_ff;

   assign link_on = spi_ctrl_ff[RSL_BIT_LINK_EN];
   assign wr_pin  = acc_ff && i_avs_write && i_avs_address == RSL_ADDR_PIN_CTRL;
   assign wr_data = acc_ff && i_avs_write && i_avs_address == RSL_ADDR_SHIFT_DATA;
   assign wr_ctl  = acc_ff && i_avs_write && i_avs_address == RSL_ADDR_SPI_CTRL;

   rsl_clk_div u_div (
      .i_clock     (i_clock),
      .i_reset_n   (i_reset_n),
      .i_run       (state_ff == RSL_SHIFT),
      .i_div_code  (spi_ctrl_ff[3:0]),
      .o_half_tick (half_tick)
   );

   // every access waits one cycle; acc_ff marks the answering edge
   // waitrequest idles high so that it can come straight from a flop
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         acc_ff            <= 1'b0;
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata    <= 32'h0000_0000;
      end else begin
         acc_ff            <= (i_avs_read || i_avs_write) && !acc_ff;
         o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !acc_ff);
         if ((i_avs_read || i_avs_write) && !acc_ff) begin
            case (i_avs_address)
               RSL_ADDR_PIN_CTRL:   o_avs_readdata <= {24'h0, 5'h0, pin_ctrl_ff[2:0]};
               RSL_ADDR_SHIFT_DATA: o_avs_readdata <= {24'h0, shift_ff};
               RSL_ADDR_SPI_CTRL:   o_avs_readdata <= {24'h0, 3'h0, spi_ctrl_ff[4:0]};
               RSL_ADDR_STATUS:     o_avs_readdata <= {31'h0, state_ff != RSL_IDLE};
               default:             o_avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // control registers
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pin_ctrl_ff <= RSL_RST_PIN_CTRL;
         spi_ctrl_ff <= RSL_RST_SPI_CTRL;
      end else begin
         if (wr_pin) begin
            pin_ctrl_ff <= {5'h0, i_avs_writedata[2:0]};
         end
         if (wr_ctl) begin
            spi_ctrl_ff <= {3'h0, i_avs_writedata[4:0]};
         end
      end
   end

   // pin outputs registered from the control bits
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         csn_ff    <= 1'b1;
         ce_ff     <= 1'b0;
         clk_en_ff <= 1'b0;
      end else begin
         csn_ff    <= pin_ctrl_ff[RSL_BIT_CSN];
         ce_ff     <= pin_ctrl_ff[RSL_BIT_RADIO_EN];
         clk_en_ff <= pin_ctrl_ff[RSL_BIT_CLK_EN];
      end
   end

   // watch the select edge; while idle, the data register is loaded two cycles
   // after the edge with the status byte kept from the previous command
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         csn_prev_ff    <= 1'b1;
         load_status_ff <= 1'b0;
      end else begin
         csn_prev_ff    <= csn_ff;
         load_status_ff <= csn_prev_ff && !csn_ff;
      end
   end

   // byte shifter, msb first, mode 0
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_ff    <= RSL_IDLE;
         shift_ff    <= RSL_RST_SHIFT_DATA;
         half_cnt_ff <= 4'h0;
         sck_ff      <= 1'b0;
         mosi_ff     <= 1'b0;
      end else begin
         case (state_ff)
            RSL_IDLE: begin
               sck_ff <= 1'b0;
               if (wr_data && link_on) begin
                  shift_ff    <= {i_avs_writedata[6:0], 1'b0}; // msb is already on the line
                  mosi_ff     <= i_avs_writedata[7];
                  half_cnt_ff <= 4'h0;
                  state_ff    <= RSL_SHIFT;
               end else if (wr_data) begin
                  shift_ff <= i_avs_writedata[7:0];
               end else if (load_status_ff) begin
                  shift_ff <= status_byte_ff;
               end
            end
            RSL_SHIFT: begin
               if (!link_on) begin
                  sck_ff   <= 1'b0;
                  state_ff <= RSL_IDLE;
               end else if (half_tick) begin
                  sck_ff      <= ~sck_ff;
                  half_cnt_ff <= half_cnt_ff + 4'h1;
                  if (!sck_ff) begin
                     shift_ff[0] <= link.miso; // sample on rising edge
                  end else if (half_cnt_ff == 4'hf) begin
                     state_ff <= RSL_DONE;
                  end else begin
                     mosi_ff  <= shift_ff[7];
                     shift_ff <= {shift_ff[6:0], 1'b0};
                  end
               end
            end
            RSL_DONE: begin
               state_ff <= RSL_IDLE;
            end
            default: state_ff <= RSL_IDLE;
         endcase
      end
   end

   // status arrives as the first returned byte of a command; kept for the next
   // select reload, so the reloaded value is one command old
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         first_ff       <= 1'b0;
         status_byte_ff <= 8'h00;
      end else if (load_status_ff) begin
         first_ff <= 1'b1;
      end else if (state_ff == RSL_DONE && first_ff) begin
         first_ff       <= 1'b0;
         status_byte_ff <= shift_ff;
      end
   end

   assign link.sck         = sck_ff;
   assign link.mosi        = mosi_ff;
   assign link.csn         = csn_ff;
   assign link.ce          = ce_ff;
   assign link.core_clk_en = clk_en_ff;
endmodule : rsl_ctrl
`default_nettype wire

/* File: verilog/rsl_radio.sv */
`timescale 1ns/1ps
`default_nettype none
// radio-side command decoder; registers are a simplified store, fifos are only strobes and an input byte
module rsl_radio
   import rsl_pkg::*;
(
   input  wire logic       i_clock,
   input  wire logic       i_reset_n,
   rsl_link_if.radio       link,
   input  wire logic [7:0] i_status,
   input  wire logic       i_standby,
   input  wire logic [5:0] i_rx_width,
   input  wire logic [7:0] i_rx_byte,
   output logic [7:0]      o_cmd,
   output logic            o_cmd_pulse,
   output logic [7:0]      o_wr_byte,
   output logic            o_wr_pulse,
   output logic            o_rx_pop,
   output logic            o_flush_tx,
   output logic            o_flush_rx,
   output logic            o_reuse,
   output logic            o_features_on,
   output logic            o_noack
);
   logic [7:0] regs_ff [RSL_NUM_REGS][RSL_MAX_REG_BYTES];
   logic       sck_d_ff;
   logic       csn_d_ff;
   logic [2:0] bit_ff;
   logic [7:0] rx_sh_ff;
   logic [7:0] tx_sh_ff;
   logic [5:0] byte_ff;
   logic [7:0] cmd_ff;
   logic [7:0] next_out;
   logic       rise;
   logic       fall;
   logic       byte_end;
   logic [7:0] full_byte;
   logic       is_reg_wr;

   assign rise      = link.sck && !sck_d_ff && !link.csn;
   assign fall      = !link.sck && sck_d_ff && !link.csn;
   assign full_byte = {rx_sh_ff[6:0], link.mosi};
   assign byte_end  = rise && bit_ff == 3'h7;
   assign is_reg_wr = cmd_ff[7:5] == 3'b001;

   // reply byte for the next slot, low byte first
   always_comb begin
      next_out = 8'h00;
      if (cmd_ff[7:5] == 3'b000 && byte_ff != 6'h00 && byte_ff <= 6'd5) begin
         next_out = regs_ff[cmd_ff[4:0]][3'(byte_ff - 6'd1)];
      end else if (cmd_ff == RSL_CMD_RX_READ) begin
         next_out = i_rx_byte;
      end else if (cmd_ff == RSL_CMD_RX_WIDTH && o_features_on) begin
         next_out = {2'h0, i_rx_width};
      end
   end

   // serial engine; status goes out first after select
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sck_d_ff <= 1'b0;
         csn_d_ff <= 1'b1;
         bit_ff   <= 3'h0;
         rx_sh_ff <= 8'h00;
         tx_sh_ff <= 8'h00;
         byte_ff  <= 6'h00;
         cmd_ff   <= RSL_CMD_NOP;
      end else begin
         sck_d_ff <= link.sck;
         csn_d_ff <= link.csn;
         if (link.csn) begin
            bit_ff   <= 3'h0;
            byte_ff  <= 6'h00;
            tx_sh_ff <= i_status;
         end else if (rise) begin
            rx_sh_ff <= full_byte;
            bit_ff   <= bit_ff + 3'h1;
            if (byte_end) begin
               byte_ff <= byte_ff + 6'h01;
               if (byte_ff == 6'h00) begin
                  cmd_ff <= full_byte;
               end
            end
         end else if (fall) begin
            tx_sh_ff <= (bit_ff == 3'h0) ? next_out : {tx_sh_ff[6:0], 1'b0};
         end
      end
   end
   // the next bit shows in the cycle its falling edge is seen, so that the
   // fastest rate, which rises again at the next edge, samples the new bit
   assign link.miso = fall ? ((bit_ff == 3'h0) ? next_out[7] : tx_sh_ff[6]) : tx_sh_ff[7];

   // register writes, only bytes actually received change
   always_ff @(posedge i_clock) begin
      if (byte_end && byte_ff != 6'h00 && byte_ff <= 6'd5 && is_reg_wr && i_standby) begin
         regs_ff[cmd_ff[4:0]][3'(byte_ff - 6'd1)] <= full_byte;
      end
   end

   // command effects and data strobes
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_cmd         <= 8'h00;
         o_cmd_pulse   <= 1'b0;
         o_wr_byte     <= 8'h00;
         o_wr_pulse    <= 1'b0;
         o_rx_pop      <= 1'b0;
         o_flush_tx    <= 1'b0;
         o_flush_rx    <= 1'b0;
         o_reuse       <= 1'b0;
         o_features_on <= 1'b0;
         o_noack       <= 1'b0;
      end else begin
         o_cmd_pulse <= byte_end && byte_ff == 6'h00;
         o_wr_pulse  <= 1'b0;
         o_flush_tx  <= byte_end && byte_ff == 6'h00 && full_byte == RSL_CMD_FLUSH_TX;
         o_flush_rx  <= byte_end && byte_ff == 6'h00 && full_byte == RSL_CMD_FLUSH_RX;
         o_rx_pop    <= !csn_d_ff && link.csn && cmd_ff == RSL_CMD_RX_READ && byte_ff > 6'h01;
         if (byte_end && byte_ff == 6'h00) begin
            o_cmd <= full_byte;
            if (full_byte == RSL_CMD_REUSE) o_reuse <= 1'b1;
            if (full_byte == RSL_CMD_TX_WRITE || full_byte == RSL_CMD_FLUSH_TX) o_reuse <= 1'b0;
            o_noack <= full_byte == RSL_CMD_NOACK_WR && o_features_on;
         end
         if (byte_end && byte_ff != 6'h00 && byte_ff <= 6'd32) begin
            if (cmd_ff == RSL_CMD_TX_WRITE ||
                (o_features_on && (cmd_ff == RSL_CMD_NOACK_WR ||
                 (cmd_ff[7:3] == RSL_ACK_WR_PREFIX && cmd_ff[2:0] <= RSL_MAX_PIPE)))) begin
               o_wr_byte  <= full_byte;
               o_wr_pulse <= 1'b1;
            end
            if (cmd_ff == RSL_CMD_ACTIVATE && byte_ff == 6'h01 &&
                full_byte == RSL_ACTIVATE_KEY && i_standby) begin
               o_features_on <= ~o_features_on;
            end
         end
      end
   end
endmodule : rsl_radio
`default_nettype wire

/* File: verification/rsl_link_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module rsl_link_monitor (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic sck,
   input wire logic mosi,
   input wire logic miso,
   input wire logic csn,
   input wire logic ce,
   input wire logic core_clk_en
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   logic [5:0] hi_ff;   // cycles the serial clock has stayed high
   logic [2:0] rise_ff; // serial clock rises, modulo one byte
   logic       sck_ff;  // serial clock one sample back
   // counters kept here so no property needs a long repetition
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         hi_ff   <= 6'h00;
         rise_ff <= 3'h0;
         sck_ff  <= 1'b0;
      end else begin
         hi_ff   <= sck ? hi_ff + 6'h01 : 6'h00;
         rise_ff <= rise_ff + {2'h0, sck & ~sck_ff};
         sck_ff  <= sck;
      end
   end
   AST_IDLE_LOW: assert property (csn |-> !sck)
      else $error("serial clock high while deselected");
   AST_MOSI_HOLD: assert property (sck && sck_ff |-> $stable(mosi))
      else $error("data line moved while serial clock high");
   AST_HIGH_SPAN: assert property (sck |-> hi_ff < 6'd32)
      else $error("serial clock high longer than slowest rate");
   AST_HIGH_ENDS: assert property ($rose(sck) |-> ##[1:32] !sck)
      else $error("serial clock did not fall in time");
   AST_WHOLE_BYTES: assert property ($rose(csn) |-> rise_ff == 3'h0)
      else $error("selection ended inside a byte");
   AST_RESET_STATE: assert property ($rose(i_reset_n) |-> csn && !ce && !core_clk_en && !sck)
      else $error("link pins not at reset state");
   AST_PINS_STILL: assert property (sck |-> $stable({csn, ce, core_clk_en}))
      else $error("control pins moved during a bit");
   AST_SELECT_SETTLE: assert property ($fell(csn) |-> !sck [*2])
      else $error("serial clock ran right at selection");
   // main scenarios: slowest rate, whole command, returned ones, enable line
   COV_SLOW: cover property (sck && hi_ff == 6'd31);
   COV_BYTE: cover property ($rose(csn));
   COV_MISO: cover property (!csn && miso);
   COV_ENABLE: cover property ($rose(ce));
endmodule // rsl_link_monitor
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rsl_pkg::*;
   logic        i_clock = 1'b0;
   logic        i_reset_n = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        waitreq;
   logic [7:0]  status = 8'h5a;
   logic        standby = 1'b1;
   logic [7:0]  cmd_seen;
   logic [7:0]  wr_byte;
   logic [7:0]  mosi_sh;
   logic        wr_p, pop, ftx, frx, reuse, feat, noack;
   int          ev[4] = '{0, 0, 0, 0};
   int          cyc = 0;
   int          last = 0;
   int          per = 0;
   int          num_errors = 0;
   int          check_count = 0;
   rsl_link_if  link ();
   rsl_ctrl rsl_ctrl_i (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_avs_address(addr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
      .o_avs_waitrequest(waitreq), .link(link));
   rsl_radio rsl_radio_i (.i_clock(i_clock), .i_reset_n(i_reset_n), .link(link),
      .i_status(status), .i_standby(standby), .i_rx_width(6'h11), .i_rx_byte(8'hc3),
      .o_cmd(cmd_seen), .o_cmd_pulse(), .o_wr_byte(wr_byte), .o_wr_pulse(wr_p),
      .o_rx_pop(pop), .o_flush_tx(ftx), .o_flush_rx(frx), .o_reuse(reuse),
      .o_features_on(feat), .o_noack(noack));
   rsl_link_monitor rsl_link_monitor_i (.i_clock(i_clock), .i_reset_n(i_reset_n),
      .sck(link.sck), .mosi(link.mosi), .miso(link.miso), .csn(link.csn), .ce(link.ce),
      .core_clk_en(link.core_clk_en));
   always #20 i_clock = ~i_clock;
   // wire byte and serial clock period, taken at each rise
   always @(posedge link.sck) begin
      mosi_sh <= {mosi_sh[6:0], link.mosi};
      per <= cyc - last;
      last <= cyc;
   end
   // running counts of the radio pulses; a pulse lasts one cycle only
   always @(posedge i_clock) begin
      cyc++;
      ev[0] += wr_p;
      ev[1] += pop;
      ev[2] += ftx;
      ev[3] += frx;
   end
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      $display("checks %0d, errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // one access; the request is held until waitrequest is seen low
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      n = 0;
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= {24'h0, d};
      do begin
         @(posedge i_clock);
         n++;
      end while (waitreq !== 1'b0 && n < 20);
      q = rdata[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 20) begin
         cmp("bus answer", 0, 1);
         close_out();
      end
      @(posedge i_clock);
   endtask
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(a, 1'b1, d, q);
   endtask
   // one byte over the link; busy is polled since nothing blocks a second write
   task automatic xfer(input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      wr8(RSL_ADDR_SHIFT_DATA, d);
      do begin
         bus(RSL_ADDR_STATUS, 1'b0, 8'h00, q);
         n++;
      end while (q[0] !== 1'b0 && n < 400);
      if (n >= 400) begin
         cmp("transfer end", 0, 1);
         close_out();
      end
      cmp("wire byte", d, mosi_sh);
      bus(RSL_ADDR_SHIFT_DATA, 1'b0, 8'h00, q);
   endtask
   // a whole command: select, bytes, deselect
   task automatic cmd(input logic [7:0] tx[$], output logic [7:0] rx[$]);
      logic [7:0] q;
      rx = {};
      wr8(RSL_ADDR_PIN_CTRL, 8'h06);
      wr8(RSL_ADDR_PIN_CTRL, 8'h04);
      foreach (tx[i]) begin
         xfer(tx[i], q);
         rx.push_back(q);
      end
      wr8(RSL_ADDR_PIN_CTRL, 8'h06);
   endtask
   task automatic t_regs();
      logic [7:0] q;
      bus(RSL_ADDR_PIN_CTRL, 1'b0, 8'h00, q);
      cmp("pin reset", RSL_RST_PIN_CTRL, q);
      bus(RSL_ADDR_SPI_CTRL, 1'b0, 8'h00, q);
      cmp("ctrl reset", RSL_RST_SPI_CTRL, q);
      wr8(RSL_ADDR_SPI_CTRL, 8'hff);
      bus(RSL_ADDR_SPI_CTRL, 1'b0, 8'h00, q);
      cmp("ctrl bits", 8'h1f, q);
      wr8(RSL_ADDR_PIN_CTRL, 8'hfd);
      bus(RSL_ADDR_PIN_CTRL, 1'b0, 8'h00, q);
      cmp("pin bits", 8'h05, q);
      cmp("link pins", 3'b101, {link.core_clk_en, link.csn, link.ce});
      wr8(RSL_ADDR_PIN_CTRL, 8'h02);
      @(posedge i_clock); // pins follow the register one cycle later
      cmp("link pins", 3'b010, {link.core_clk_en, link.csn, link.ce});
   endtask
   // a data write with the link off is kept but never shifted
   task automatic t_off();
      logic [7:0] q;
      int n;
      n = 0;
      wr8(RSL_ADDR_SPI_CTRL, 8'h02);
      wr8(RSL_ADDR_PIN_CTRL, 8'h00);
      wr8(RSL_ADDR_SHIFT_DATA, 8'h3c);
      repeat (200) begin
         @(posedge i_clock);
         n += link.sck;
      end
      cmp("clock while off", 0, n);
      bus(RSL_ADDR_SHIFT_DATA, 1'b0, 8'h00, q);
      cmp("stored byte", 8'h3c, q);
      wr8(RSL_ADDR_PIN_CTRL, 8'h02);
   endtask
   task automatic t_div();
      logic [3:0] code[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hf};
      int exp[8] = '{2, 2, 4, 8, 16, 32, 64, 64};
      logic [7:0] rx[$];
      foreach (code[i]) begin
         wr8(RSL_ADDR_SPI_CTRL, {4'h1, code[i]});
         cmd({RSL_CMD_NOP}, rx);
         cmp("serial period", exp[i], per);
         cmp("status at rate", status, rx[0]);
      end
   endtask
   task automatic t_regfile();
      logic [7:0] rx[$];
      logic [7:0] exp[5] = '{8'h99, 8'h22, 8'h33, 8'h44, 8'h55};
      wr8(RSL_ADDR_SPI_CTRL, 8'h12);
      cmd({RSL_CMD_NOP}, rx);
      cmp("status byte", status, rx[0]);
      cmp("command seen", RSL_CMD_NOP, cmd_seen);
      cmd({8'h25, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55}, rx);
      cmd({8'h25, 8'h99}, rx);
      cmd({8'h05, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff}, rx);
      foreach (exp[i]) cmp("register byte", exp[i], rx[i + 1]);
      standby <= 1'b0;
      cmd({8'h25, 8'h77}, rx);
      cmd({8'h05, 8'hff}, rx);
      cmp("locked register", 8'h99, rx[1]);
      standby <= 1'b1;
   endtask
   task automatic t_fifo();
      logic [7:0] rx[$];
      int e[4];
      e = ev;
      cmd({RSL_CMD_REUSE}, rx);
      cmp("reuse on", 1'b1, reuse);
      cmd({RSL_CMD_FLUSH_TX}, rx);
      cmp("reuse off", 1'b0, reuse);
      cmd({RSL_CMD_FLUSH_RX}, rx);
      cmd({RSL_CMD_TX_WRITE, 8'h6b}, rx);
      cmp("payload byte", 8'h6b, wr_byte);
      cmd({RSL_CMD_RX_READ, 8'hff}, rx);
      cmp("payload read", 8'hc3, rx[1]);
      repeat (4) @(posedge i_clock); // the pop pulse follows deselection
      for (int i = 0; i < 4; i++) cmp("pulse count", 1, ev[i] - e[i]);
      cmd({RSL_CMD_RX_WIDTH, 8'hff}, rx);
      cmp("width while off", 8'h00, rx[1]);
      cmd({RSL_CMD_ACTIVATE, RSL_ACTIVATE_KEY}, rx);
      cmp("features", 1'b1, feat);
      cmd({RSL_CMD_RX_WIDTH, 8'hff}, rx);
      cmp("payload width", 8'h11, rx[1]);
      cmd({RSL_CMD_NOACK_WR, 8'h12}, rx);
      cmp("no ack", 1'b1, noack);
      cmd({8'ha9, 8'h3e}, rx);
      cmp("ack payload", 8'h3e, wr_byte);
      cmd({8'hae, 8'h41}, rx);
      cmp("bad pipe", 8'h3e, wr_byte);
      cmd({RSL_CMD_ACTIVATE, RSL_ACTIVATE_KEY}, rx);
      cmp("features", 1'b0, feat);
   endtask
   // reset, then the scenarios in turn
   initial begin
      repeat (4) @(posedge i_clock);
      i_reset_n <= 1'b1;
      t_regs();
      t_off();
      t_div();
      t_regfile();
      t_fifo();
      close_out();
   end
endmodule // tb_top
`default_nettype wire
